// >>> rtl/see_pkg.sv
// shared constants, types and helpers for the two-wire eeprom pair
package see_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 4;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYC_DEF = WRITE_TIME_NS / CLK_NS;
  localparam int INIT_TIME_NS  = 1000;
  localparam int INIT_CYC      = (INIT_TIME_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // framing and variants
  // ---------------------------------------------------------------
  // type code value is arbitrary
  localparam logic [3:0] DEV_TYPE_CODE = 4'h6;
  localparam int         KBIT_DEF      = 2;
  localparam int         ADDR_W        = 11;
  localparam int         PAGE_MAX      = 16;
  localparam logic [3:0] LAST_BIT      = 4'h8;
  localparam logic [7:0] MEM_INIT      = 8'hff;

  typedef enum logic [2:0] {D_INIT, D_IDLE, D_DEV, D_WADR, D_DATA, D_READ, D_PROG} see_dev_e;
  typedef enum logic [2:0] {H_INIT, H_IDLE, H_START, H_LOAD, H_BIT, H_ACK, H_STOP} see_host_e;

  function automatic int page_size(input int kbit);
    return (kbit == 2) ? 8 : 16;
  endfunction

  // address bits compared with straps; the rest pick a 256-byte block
  function automatic logic [2:0] cs_mask(input int kbit);
    unique case (kbit)
      2:       return 3'h7;
      4:       return 3'h6;
      8:       return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

endpackage

// >>> rtl/see_if.sv
// two-wire bus between the eeprom and its master
`timescale 1ns/1ps
`default_nettype none
interface see_if;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda;

  // wired-and of the open-drain drivers with an idle pull-up
  assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));

  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
endinterface
`default_nettype wire

// >>> rtl/see_eeprom_dev.sv
// two-wire serial eeprom slave: write path, page buffer and array
// How it works
// - a start condition opens every transaction
// - stop during read returns to standby
// - stop during write starts programming once a data byte is held
// - data changes only while clock low
// - eight-bit units, acknowledge in ninth clock
// - programming cycle ignores bus, never acknowledges
// - three address bits, rw bit, type code
// - 2 kbit: three straps compared
// - 4 kbit: two straps, one block bit
// - 8 kbit: one strap, two block bits
// - 16 kbit: no straps, three block bits
// - open strap reads as zero
// - byte write: address, word address, data, stop
// - page holds 8 or 16 bytes
// - each further data byte acknowledged, next address
// - program only bytes received, from start address
// - 2 kbit: low three bits wrap
// - larger parts: low four bits wrap
// - write protect high blocks all writes
// - protected: no acknowledge after data bytes
// - array starts all ones
// - power-on initialisation before first start
`timescale 1ns/1ps
`default_nettype none
module see_eeprom_dev
  import see_pkg::*;
#(
  parameter int KBIT      = KBIT_DEF,
  parameter int WRITE_CYC = WRITE_CYC_DEF
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // bus pins
  see_if.dev                     bus,
  // straps and protection
  input  wire logic              chip_select_strap_bit0,
  input  wire logic              chip_select_strap_bit1,
  input  wire logic              chip_select_strap_bit2,
  input  wire logic              write_protect,
  // status and array read-back
  output logic                   busy,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0]             rd_data
);

  // ---------------------------------------------------------------
  // derived sizes
  // ---------------------------------------------------------------
  localparam int              MEM_BYTES = KBIT * 128;
  localparam int              AW        = $clog2(MEM_BYTES);
  localparam int              PAGE      = page_size(KBIT);
  localparam int              TW        = $clog2(WRITE_CYC + INIT_CYC + 1);
  localparam logic [2:0]      CSM       = cs_mask(KBIT);
  localparam logic [3:0]      PM4       = 4'(PAGE - 1);
  localparam logic [ADDR_W-1:0] PM      = ADDR_W'(PAGE - 1);

  generate
    if (!(KBIT == 2 || KBIT == 4 || KBIT == 8 || KBIT == 16)) begin : g_bad_kbit
      $error("KBIT must be 2, 4, 8 or 16");
    end
    // commit of a full page must finish inside the timed cycle
    if (WRITE_CYC <= PAGE_MAX || INIT_CYC < 1) begin : g_bad_cyc
      $error("WRITE_CYC too small");
    end
  endgenerate

  typedef struct packed {
    logic [1:0]                  sy1;   // {scl, sda}
    logic [1:0]                  sy2;
    logic [1:0]                  sy3;
    logic [1:0]                  flt;
    logic [1:0]                  fprv;
    logic [2:0]                  cs1;
    logic [2:0]                  cs2;
    logic                        wp1;
    logic                        wp2;
    see_dev_e                    st;
    logic [3:0]                  bitn;
    logic                        ack_ph;
    logic [7:0]                  sh;
    logic [2:0]                  blk;
    logic [7:0]                  waddr;
    logic [3:0]                  cnt;
    logic [PAGE_MAX-1:0][7:0]    pbuf;
    logic [PAGE_MAX-1:0]         pval;
    logic [4:0]                  cidx;
    logic [TW-1:0]               tmr;
    logic                        sda_o;
    logic                        sda_oe;
    logic                        busy;
  } see_dev_s;

  see_dev_s                      r_ff;
  see_dev_s                      nxt_r;
  logic [7:0]                    mem [0:MEM_BYTES-1];
  logic [7:0]                    rd_data_ff;
  logic                          mem_we;
  logic [ADDR_W-1:0]             mem_a;
  logic [7:0]                    mem_d;
  logic                          start_c;
  logic                          stop_c;
  logic                          rise_c;
  logic                          fall_c;
  logic [3:0]                    pos_c;

  // ---------------------------------------------------------------
  // line events from filtered samples
  // ---------------------------------------------------------------
  assign start_c = r_ff.flt[1] && r_ff.fprv[1] && r_ff.fprv[0] && !r_ff.flt[0];
  assign stop_c  = r_ff.flt[1] && r_ff.fprv[1] && !r_ff.fprv[0] && r_ff.flt[0];
  assign rise_c  = r_ff.flt[1] && !r_ff.fprv[1];
  assign fall_c  = !r_ff.flt[1] && r_ff.fprv[1];
  assign pos_c   = (r_ff.waddr[3:0] + r_ff.cnt) & PM4;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_r  = r_ff;
    mem_we = 1'b0;
    mem_a  = '0;
    mem_d  = '0;
    nxt_r.sy1  = {bus.scl, bus.sda};
    nxt_r.sy2  = r_ff.sy1;
    nxt_r.sy3  = r_ff.sy2;
    // two equal samples in a row needed: one-cycle spikes are dropped
    for (int i = 0; i < 2; i++) begin
      if (r_ff.sy2[i] == r_ff.sy3[i]) begin
        nxt_r.flt[i] = r_ff.sy2[i];
      end
    end
    nxt_r.fprv = r_ff.flt;
    // open straps are pulled down on the board, so they arrive as zero
    nxt_r.cs1  = {chip_select_strap_bit2, chip_select_strap_bit1, chip_select_strap_bit0};
    nxt_r.cs2  = r_ff.cs1;
    nxt_r.wp1  = write_protect;
    nxt_r.wp2  = r_ff.wp1;

    if (r_ff.st == D_INIT) begin
      nxt_r.tmr = r_ff.tmr + 1'b1;
      if (r_ff.tmr == TW'(INIT_CYC - 1)) begin
        nxt_r.st  = D_IDLE;
        nxt_r.tmr = '0;
      end
    end else if (r_ff.st == D_PROG) begin
      // bus is not looked at here at all
      if (r_ff.cidx < 5'(PAGE)) begin
        mem_we       = r_ff.pval[r_ff.cidx[3:0]];
        mem_a        = ({r_ff.blk, r_ff.waddr} & ~PM) | ADDR_W'(r_ff.cidx[3:0]);
        mem_d        = r_ff.pbuf[r_ff.cidx[3:0]];
        nxt_r.cidx   = r_ff.cidx + 1'b1;
      end
      nxt_r.tmr = r_ff.tmr + 1'b1;
      if (r_ff.tmr == TW'(WRITE_CYC - 1)) begin
        nxt_r.st   = D_IDLE;
        nxt_r.pval = '0;
      end
    end else if (start_c) begin
      nxt_r.st     = D_DEV;
      nxt_r.bitn   = '0;
      nxt_r.ack_ph = 1'b0;
      nxt_r.sda_oe = 1'b0;
    end else if (stop_c) begin
      nxt_r.bitn   = '0;
      nxt_r.ack_ph = 1'b0;
      nxt_r.sda_oe = 1'b0;
      if (r_ff.st == D_DATA && |r_ff.pval) begin
        nxt_r.st   = D_PROG;
        nxt_r.cidx = '0;
        nxt_r.tmr  = '0;
      end else begin
        nxt_r.st   = D_IDLE;
      end
    end else if (r_ff.st != D_IDLE) begin
      if (rise_c && !r_ff.ack_ph) begin
        nxt_r.sh   = {r_ff.sh[6:0], r_ff.flt[0]};
        nxt_r.bitn = r_ff.bitn + 1'b1;
      end else if (fall_c && r_ff.ack_ph) begin
        nxt_r.ack_ph = 1'b0;
        nxt_r.sda_oe = 1'b0;
        nxt_r.bitn   = '0;
      end else if (fall_c && r_ff.bitn == LAST_BIT) begin
        nxt_r.ack_ph = 1'b1;
        unique case (r_ff.st)
          D_DEV: begin
            if (r_ff.sh[7:4] == DEV_TYPE_CODE && ((r_ff.sh[3:1] ^ r_ff.cs2) & CSM) == 3'h0) begin
              nxt_r.sda_oe = 1'b1;
              nxt_r.blk    = r_ff.sh[3:1] & ~CSM;
              nxt_r.st     = r_ff.sh[0] ? D_READ : D_WADR;
            end else begin
              nxt_r.st     = D_IDLE;
              nxt_r.ack_ph = 1'b0;
            end
          end
          D_WADR: begin
            nxt_r.waddr  = r_ff.sh;
            nxt_r.cnt    = '0;
            nxt_r.pval   = '0;
            nxt_r.sda_oe = 1'b1;
            nxt_r.st     = D_DATA;
          end
          D_DATA: begin
            if (!r_ff.wp2) begin
              nxt_r.pbuf[pos_c] = r_ff.sh;
              nxt_r.pval[pos_c] = 1'b1;
              nxt_r.cnt         = r_ff.cnt + 1'b1;
              nxt_r.sda_oe      = 1'b1;
            end
          end
          // read data path lives elsewhere; just keep byte framing
          D_READ, D_IDLE, D_INIT, D_PROG: begin
            nxt_r.ack_ph = 1'b0;
            nxt_r.bitn   = '0;
          end
        endcase
      end
    end
    nxt_r.sda_o = 1'b0;
    nxt_r.busy  = (nxt_r.st == D_INIT) || (nxt_r.st == D_PROG);
  end

  // ---------------------------------------------------------------
  // state and array
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_ff      <= '0;
      r_ff.busy <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // array is filled with MEM_INIT (all ones) on reset to stand in for the erased state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= MEM_INIT;
      end
      rd_data_ff <= '0;
    end else begin
      if (mem_we) begin
        mem[mem_a[AW-1:0]] <= mem_d;
      end
      rd_data_ff <= mem[rd_addr[AW-1:0]];
    end
  end

  assign bus.sda_dev_o  = r_ff.sda_o;
  assign bus.sda_dev_oe = r_ff.sda_oe;
  assign busy           = r_ff.busy;
  assign rd_data        = rd_data_ff;

endmodule
`default_nettype wire

// >>> rtl/see_eeprom_host.sv
// two-wire master that issues byte and page writes to the eeprom
`timescale 1ns/1ps
`default_nettype none
module see_eeprom_host
  import see_pkg::*;
#(
  parameter int QTR   = QTR_CYC,
  parameter int DEPTH = 2,
  parameter int DW    = 8
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // bus pins
  see_if.host                bus,
  // command
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic [2:0]    cmd_sel,
  input  wire logic [7:0]    cmd_waddr,
  input  wire logic [4:0]    cmd_len,
  // write data stream
  input  wire logic          data_valid,
  output logic               data_ready,
  input  wire logic [DW-1:0] data_byte,
  // result
  output logic               done,
  output logic               nack
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam int QW = $clog2(QTR + INIT_CYC + 1);

  generate
    if (QTR < 4 || DW != 8 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("QTR >= 4, DW == 8, DEPTH a power of two >= 2");
    end
  endgenerate

  typedef struct packed {
    see_host_e                st;
    logic [1:0]               ph;
    logic [QW-1:0]            q;
    logic [2:0]               bitn;
    logic [7:0]               sh;
    logic [4:0]               bi;
    logic [4:0]               len;
    logic [2:0]               sel;
    logic [7:0]               waddr;
    logic [DEPTH-1:0][DW-1:0] fb;
    logic [PW-1:0]            wp;
    logic [PW-1:0]            rp;
    logic [CW-1:0]            fc;
    logic                     sy1;
    logic                     sy2;
    logic                     scl;
    logic                     sda_o;
    logic                     sda_oe;
    logic                     nack;
    logic                     done;
    logic                     cmd_rdy;
    logic                     dat_rdy;
  } see_host_s;

  see_host_s r_ff;
  see_host_s nxt_r;
  logic      tick_c;
  logic      push_c;

  assign tick_c = r_ff.q == QW'(QTR - 1);
  assign push_c = data_valid && r_ff.dat_rdy;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.sy1  = bus.sda;
    nxt_r.sy2  = r_ff.sy1;
    nxt_r.q    = tick_c ? '0 : r_ff.q + 1'b1;
    if (push_c) begin
      nxt_r.fb[r_ff.wp] = data_byte;
      nxt_r.wp          = r_ff.wp + 1'b1;
    end
    unique case (r_ff.st)
      H_INIT: begin
        nxt_r.scl = 1'b1;
        nxt_r.q   = r_ff.q + 1'b1;
        // first start only once the slave has come out of its own init
        if (r_ff.q == QW'(INIT_CYC + QTR)) begin
          nxt_r.st = H_IDLE;
          nxt_r.q  = '0;
        end
      end
      H_IDLE: begin
        if (cmd_valid && r_ff.cmd_rdy) begin
          nxt_r.sel   = cmd_sel;
          nxt_r.waddr = cmd_waddr;
          nxt_r.len   = cmd_len;
          nxt_r.bi    = '0;
          nxt_r.nack  = 1'b0;
          nxt_r.ph    = '0;
          nxt_r.q     = '0;
          nxt_r.st    = H_START;
        end
      end
      H_START: begin
        if (tick_c) begin
          nxt_r.ph = r_ff.ph + 1'b1;
          if (r_ff.ph == 2'd1) nxt_r.sda_oe = 1'b1;
          if (r_ff.ph == 2'd3) begin
            nxt_r.scl = 1'b0;
            nxt_r.st  = H_LOAD;
          end
        end
      end
      H_LOAD: begin
        // scl parks high here if the data buffer runs dry
        if (r_ff.bi == 5'd0) begin
          nxt_r.sh = {DEV_TYPE_CODE, r_ff.sel, 1'b0};
          nxt_r.st = H_BIT;
        end else if (r_ff.bi == 5'd1) begin
          nxt_r.sh = r_ff.waddr;
          nxt_r.st = H_BIT;
        end else if (r_ff.fc != '0) begin
          nxt_r.sh = r_ff.fb[r_ff.rp];
          nxt_r.rp = r_ff.rp + 1'b1;
          nxt_r.st = H_BIT;
        end
        nxt_r.ph   = '0;
        nxt_r.q    = '0;
        nxt_r.bitn = '0;
      end
      H_BIT: begin
        if (tick_c) begin
          nxt_r.ph = r_ff.ph + 1'b1;
          unique case (r_ff.ph)
            2'd0: nxt_r.scl = 1'b0;
            2'd1: nxt_r.sda_oe = !r_ff.sh[7];
            2'd2: nxt_r.scl = 1'b1;
            2'd3: begin
              nxt_r.sh   = {r_ff.sh[6:0], 1'b0};
              nxt_r.bitn = r_ff.bitn + 1'b1;
              if (r_ff.bitn == 3'd7) nxt_r.st = H_ACK;
            end
          endcase
        end
      end
      H_ACK: begin
        if (tick_c) begin
          nxt_r.ph = r_ff.ph + 1'b1;
          unique case (r_ff.ph)
            2'd0: nxt_r.scl = 1'b0;
            2'd1: nxt_r.sda_oe = 1'b0;
            2'd2: nxt_r.scl = 1'b1;
            2'd3: begin
              nxt_r.bi = r_ff.bi + 1'b1;
              if (r_ff.sy2) begin
                nxt_r.nack = 1'b1;
                nxt_r.st   = H_STOP;
              end else if (r_ff.bi == r_ff.len + 5'd1) begin
                nxt_r.st   = H_STOP;
              end else begin
                nxt_r.st   = H_LOAD;
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick_c) begin
          nxt_r.ph = r_ff.ph + 1'b1;
          unique case (r_ff.ph)
            2'd0: nxt_r.scl = 1'b0;
            2'd1: nxt_r.sda_oe = 1'b1;
            2'd2: nxt_r.scl = 1'b1;
            2'd3: begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.done   = 1'b1;
              nxt_r.st     = H_IDLE;
            end
          endcase
        end
      end
    endcase
    nxt_r.fc      = r_ff.fc + CW'(push_c) - CW'(nxt_r.rp != r_ff.rp);
    nxt_r.dat_rdy = nxt_r.fc != CW'(DEPTH);
    nxt_r.cmd_rdy = nxt_r.st == H_IDLE;
    nxt_r.sda_o   = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_ff     <= '0;
      r_ff.scl <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign bus.scl         = r_ff.scl;
  assign bus.sda_host_o  = r_ff.sda_o;
  assign bus.sda_host_oe = r_ff.sda_oe;
  assign cmd_ready       = r_ff.cmd_rdy;
  assign data_ready      = r_ff.dat_rdy;
  assign done            = r_ff.done;
  assign nack            = r_ff.nack;

endmodule
`default_nettype wire

// >>> testbench/see_props.sv
// bus assertions for the two-wire eeprom pair
`timescale 1ns/1ps
`default_nettype none
module see_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  // device status
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  dev_open_drain_a: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives sda high");
  host_open_drain_a: assert property (sda_host_oe |-> !sda_host_o)
    else $error("master drives sda high");
  dev_edge_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved sda while scl high");
  busy_no_ack_a: assert property (busy |-> !sda_dev_oe)
    else $error("acknowledge while busy");
  ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
    else $error("acknowledge dropped early");
  ack_release_a: assert property ($rose(sda_dev_oe) |-> ##[1:60] !sda_dev_oe)
    else $error("acknowledge never released");
  start_hold_a: assert property (($fell(sda) && scl && $past(scl)) |-> scl [*8])
    else $error("scl fell too soon after start");
  stop_free_a: assert property (($rose(sda) && scl) |-> !sda_dev_oe)
    else $error("device holds sda at stop");
  init_idle_a: assert property ($fell(sys_rst) |-> (scl && sda) [*8])
    else $error("bus active right after reset");

  cover property ($rose(sda_dev_oe));
  cover property ($fell(sda) && scl);
  cover property ($rose(busy));
endmodule
`default_nettype wire

// >>> testbench/serial_eeprom_slave_write_tb.sv
// self-checking bench: master and eeprom joined on one bus
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_slave_write_tb import see_pkg::*; ;
  localparam logic [2:0] STRAP = 3'h5;
  localparam int         WCYC  = 1000;

  logic              clk, sys_rst, cmd_valid, data_valid, wp;
  logic              cmd_ready, data_ready, done, nack, busy;
  logic [2:0]        strap, cmd_sel;
  logic [7:0]        cmd_waddr, data_byte, rd_data;
  logic [4:0]        cmd_len;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        pdata [10];
  int                err_total, samples_checked;

  see_if bus ();
  // programming time kept long enough to outlast one address byte
  see_eeprom_dev #(.KBIT(2), .WRITE_CYC(WCYC)) see_eeprom_dev_inst (
    .clk(clk), .sys_rst(sys_rst), .bus(bus),
    .chip_select_strap_bit0(strap[0]), .chip_select_strap_bit1(strap[1]),
    .chip_select_strap_bit2(strap[2]), .write_protect(wp),
    .busy(busy), .rd_addr(rd_addr), .rd_data(rd_data));
  see_eeprom_host #(.QTR(8), .DEPTH(2), .DW(8)) see_eeprom_host_inst (
    .clk(clk), .sys_rst(sys_rst), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_sel(cmd_sel),
    .cmd_waddr(cmd_waddr), .cmd_len(cmd_len), .data_valid(data_valid),
    .data_ready(data_ready), .data_byte(data_byte), .done(done), .nack(nack));
  see_props see_props_inst (
    .clk(clk), .sys_rst(sys_rst), .scl(bus.scl), .sda(bus.sda),
    .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe),
    .sda_host_o(bus.sda_host_o), .sda_host_oe(bus.sda_host_oe), .busy(busy));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // values read right after an edge are those sampled at that edge
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    @(posedge clk);
    while (s !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, s}, {7'h0, v});
  endtask

  task automatic run_cmd(input logic [2:0] sel, input logic [7:0] wa, input logic [4:0] len);
    cmd_sel   <= sel;
    cmd_waddr <= wa;
    cmd_len   <= len;
    cmd_valid <= 1'b1;
    wait_lvl(cmd_ready, 1'b1, 20000);
    cmd_valid <= 1'b0;
    wait_lvl(done, 1'b1, 20000);
  endtask

  // valid stays up between bytes so it is never set twice in one step
  task automatic push_all(input int first, input int cnt);
    data_valid <= 1'b1;
    for (int i = first; i < first + cnt; i++) begin
      data_byte <= pdata[i];
      wait_lvl(data_ready, 1'b1, 20000);
    end
    data_valid <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    rd_addr <= a;
    repeat (2) @(posedge clk);
    chk(rd_data, e);
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_init();
    chk({7'h0, busy}, 8'h01);
    wait_lvl(busy, 1'b0, 400);
    rd_chk(11'h000, 8'hff);
    rd_chk(11'h0ff, 8'hff);
    $display("init done");
  endtask

  // byte write, then a command while programming runs
  task automatic t_byte_busy();
    pdata[0] = 8'ha5;
    fork
      run_cmd(STRAP, 8'h35, 5'd1);
      push_all(0, 1);
    join
    chk({7'h0, nack}, 8'h00);
    repeat (12) @(posedge clk);
    chk({7'h0, busy}, 8'h01);
    run_cmd(STRAP, 8'h10, 5'd0);
    chk({7'h0, nack}, 8'h01);
    wait_lvl(busy, 1'b0, 2000);
    rd_chk(11'h035, 8'ha5);
    $display("byte write done");
  endtask

  task automatic t_strap();
    run_cmd(3'h4, 8'h00, 5'd0);
    chk({7'h0, nack}, 8'h01);
    run_cmd(STRAP, 8'h20, 5'd0);
    chk({7'h0, nack}, 8'h00);
    repeat (12) @(posedge clk);
    chk({7'h0, busy}, 8'h00);
    $display("strap done");
  endtask

  // ten bytes from low bits 6: the last two wrap onto 6 and 7
  task automatic t_page();
    for (int i = 0; i < 10; i++) pdata[i] = 8'h80 + 8'(i);
    push_all(0, 2);
    @(posedge clk);
    chk({7'h0, data_ready}, 8'h00);
    fork
      run_cmd(STRAP, 8'h3e, 5'd10);
      push_all(2, 8);
    join
    chk({7'h0, nack}, 8'h00);
    // stop reaches the slave a few cycles after done; wait for busy first
    wait_lvl(busy, 1'b1, 20);
    wait_lvl(busy, 1'b0, 2000);
    for (int k = 0; k < 8; k++) rd_chk(11'h038 + 11'(k), 8'h82 + 8'(k));
    rd_chk(11'h040, 8'hff);
    $display("page write done");
  endtask

  task automatic t_protect();
    wp <= 1'b1;
    pdata[0] = 8'h5a;
    repeat (4) @(posedge clk);
    fork
      run_cmd(STRAP, 8'h35, 5'd1);
      push_all(0, 1);
    join
    chk({7'h0, nack}, 8'h01);
    repeat (12) @(posedge clk);
    chk({7'h0, busy}, 8'h00);
    rd_chk(11'h035, 8'ha5);
    wp <= 1'b0;
    $display("protect done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // all scenarios need about 9000 cycles
  initial begin
    #400000;
    err_total++;
    end_sim();
  end

  initial begin
    sys_rst    = 1'b1;
    cmd_valid  = 1'b0;
    data_valid = 1'b0;
    wp         = 1'b0;
    strap      = STRAP;
    cmd_sel    = 3'h0;
    cmd_waddr  = 8'h00;
    cmd_len    = 5'd0;
    data_byte  = 8'h00;
    rd_addr    = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_init();
    t_byte_busy();
    t_strap();
    t_page();
    t_protect();
    end_sim();
  end
endmodule
`default_nettype wire
